/* rtl/rdt_regs.vh */
// named constants for the rgb display timing and reset receiver
// assumes core clock of 40 MHz; included by bare name from rtl files
`ifndef RDT_REGS_VH
`define RDT_REGS_VH

// core clock rate
`define RDT_CLK_MHZ 40
`define RDT_CLK_KHZ 40000

// reset spike filter times in microseconds
`define RDT_T_REJECT_US 5
`define RDT_T_FULL_US 9

// reload and command waits in milliseconds
`define RDT_T_RELOAD_SLEEPIN_MS 5
`define RDT_T_RELOAD_SLEEPOUT_MS 120
`define RDT_T_SLEEP_EXIT_MS 120

// video frame shape
`define RDT_H_ACTIVE 9'h140
`define RDT_COL_W 9
`define RDT_ROW_W 9
`define RDT_PIX_W 18

// fifo word layout: {frameStart, lineStart, pixel}
`define RDT_WORD_W 20
`define RDT_WORD_SOF 19
`define RDT_WORD_SOL 18
`define RDT_FIFO_DEPTH 4
`define RDT_FIFO_AW 2

// filter, wait counter and synchroniser word widths
`define RDT_FILT_W 9
`define RDT_WAIT_W 23
`define RDT_SYNC_W 23

// bit positions in the synchroniser word
`define RDT_PIN_RST 22
`define RDT_PIN_PCLK 21
`define RDT_PIN_HS 20
`define RDT_PIN_VS 19
`define RDT_PIN_DE 18
// reset pin and both syncs idle high, so rst leaves no false spike or edge
`define RDT_PIN_IDLE 23'h58_0000

// reset filter states
`define RDT_ST_RUN 3'h0
`define RDT_ST_LOWCNT 3'h1
`define RDT_ST_HELD 3'h2
`define RDT_ST_HIGHCNT 3'h3
`define RDT_ST_RELOAD 3'h4

`endif

/* rtl/rdt_fifo.v */
// small first-in first-out buffer with valid/ready on both sides
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
module rdt_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire core_clk,
    input wire rst,
    input wire inValid,
    output wire inReady,
    input wire [WIDTH-1:0] inData,
    output wire outValid,
    input wire outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1]; // storage words
    reg [AW-1:0] wrPtr; // next slot to fill
    reg [AW-1:0] rdPtr; // next slot to drain
    reg [AW:0] fill; // words held, one bit wider than pointers
    wire doWrite;
    wire doRead;

    // honest flags straight from the fill count
    assign inReady = (fill != DEPTH[AW:0]);
    assign outValid = (fill != {(AW+1){1'b0}});
    assign outData = mem[rdPtr];
    assign doWrite = inValid & inReady;
    assign doRead = outValid & outReady;

    // pointer and count upkeep
    always @(posedge core_clk) begin
        if (rst) begin
            wrPtr <= {AW{1'b0}};
            rdPtr <= {AW{1'b0}};
            fill <= {(AW+1){1'b0}};
        end else begin
            if (doWrite) begin
                // depth is a power of two so the pointer wraps itself
                wrPtr <= wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= rdPtr + 1'b1;
            end
            if (doWrite & ~doRead) begin
                fill <= fill + 1'b1;
            end else if (doRead & ~doWrite) begin
                fill <= fill - 1'b1;
            end
        end
    end

    // storage has no reset, keeps area down
    always @(posedge core_clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end
endmodule

/* rtl/rdt_receiver.v */
// rgb pixel port receiver with hardware reset spike filter and reload wait
// assumes all link pins are asynchronous to core_clk; pixel clock is sampled
//
// Overview of operation
// - reject under 5us, reset above 9us
// - spikes inside reset pulse also rejected
// - reload settings on release, 5/120 ms
// - blank during reset, defaults at its start
`timescale 1ns/1ps
`include "rdt_regs.vh"
module rdt_receiver #(
    // long waits are parameters so a simulation can shorten them
    parameter RELOAD_SLEEPIN_CYC = `RDT_T_RELOAD_SLEEPIN_MS * `RDT_CLK_KHZ,
    parameter RELOAD_SLEEPOUT_CYC = `RDT_T_RELOAD_SLEEPOUT_MS * `RDT_CLK_KHZ,
    parameter SLEEP_EXIT_CYC = `RDT_T_SLEEP_EXIT_MS * `RDT_CLK_KHZ
) (
    input wire core_clk,
    input wire rst,
    input wire pixel_clock,
    input wire hsync_n,
    input wire vsync_n,
    input wire dataEnable,
    input wire [`RDT_PIX_W-1:0] pixel_data_bus,
    input wire hw_reset_n,
    input wire sleepOut,
    output wire pixValid,
    input wire pixReady,
    output wire [`RDT_WORD_W-1:0] pixWord,
    output reg displayBlank,
    output reg settingsReload,
    output reg settingsDefault,
    output reg commandReady,
    output reg sleepExitAllowed,
    output reg lineLengthError,
    output reg pixelOverrun
);
    // minimum cycle counts, kept in filter and wait widths
    localparam [`RDT_FILT_W-1:0] REJECT_CYC = `RDT_T_REJECT_US * `RDT_CLK_MHZ;
    localparam [`RDT_FILT_W-1:0] FULL_CYC = `RDT_T_FULL_US * `RDT_CLK_MHZ;
    localparam [`RDT_WAIT_W-1:0] SLEEPIN_W = RELOAD_SLEEPIN_CYC;
    localparam [`RDT_WAIT_W-1:0] SLEEPOUT_W = RELOAD_SLEEPOUT_CYC;
    localparam [`RDT_WAIT_W-1:0] EXIT_W = SLEEP_EXIT_CYC;

    // rising edge from two successive samples
    function rise;
        input cur;
        input prev;
        begin
            rise = cur & ~prev;
        end
    endfunction

    // two-flop synchronisers for every pin; stage one feeds only stage two
    reg [`RDT_SYNC_W-1:0] pinS1;
    reg [`RDT_SYNC_W-1:0] pinS2;
    reg [`RDT_SYNC_W-1:0] pinS3; // one more stage for edge finding
    wire [`RDT_SYNC_W-1:0] pinRaw;
    assign pinRaw = {hw_reset_n, pixel_clock, hsync_n, vsync_n, dataEnable, pixel_data_bus};

    always @(posedge core_clk) begin
        if (rst) begin
            // idle levels, not zeros: a low reset pin would open a filter run
            pinS1 <= `RDT_PIN_IDLE;
            pinS2 <= `RDT_PIN_IDLE;
            pinS3 <= `RDT_PIN_IDLE;
        end else begin
            pinS1 <= pinRaw;
            pinS2 <= pinS1;
            pinS3 <= pinS2;
        end
    end

    // named views of the synchronised pins
    wire resetPinN = pinS2[`RDT_PIN_RST];
    wire pclkEdge = rise(pinS2[`RDT_PIN_PCLK], pinS3[`RDT_PIN_PCLK]);
    // pixel fields taken from the sample just before the clock edge
    wire hsyncOld = pinS3[`RDT_PIN_HS];
    wire vsyncOld = pinS3[`RDT_PIN_VS];
    wire deOld = pinS3[`RDT_PIN_DE];
    wire [`RDT_PIX_W-1:0] pixOld = pinS3[`RDT_PIX_W-1:0];

    // reset filter state
    reg [2:0] state;
    reg [2:0] next_state;
    reg [`RDT_FILT_W-1:0] filtCnt; // length of current low or high stretch
    reg [`RDT_WAIT_W-1:0] waitCnt; // time since accepted release
    reg sleepAtReset; // sleep mode latched when reset starts
    wire inReset = (state == `RDT_ST_HELD) || (state == `RDT_ST_HIGHCNT);

    // next state of the reset filter
    always @* begin
        next_state = state;
        case (state)
            `RDT_ST_RUN, `RDT_ST_RELOAD: begin
                if (~resetPinN) begin
                    next_state = `RDT_ST_LOWCNT;
                end
            end
            `RDT_ST_LOWCNT: begin
                if (resetPinN) begin
                    // short spike, device carries on untouched
                    next_state = (waitCnt >= SLEEPOUT_W) ? `RDT_ST_RUN : `RDT_ST_RELOAD;
                end else if (filtCnt >= REJECT_CYC - 1'b1) begin
                    next_state = `RDT_ST_HELD;
                end
            end
            `RDT_ST_HELD: begin
                if (resetPinN) begin
                    next_state = `RDT_ST_HIGHCNT;
                end
            end
            `RDT_ST_HIGHCNT: begin
                if (~resetPinN) begin
                    // high spike inside the pulse neither ends nor restarts it
                    next_state = `RDT_ST_HELD;
                end else if (filtCnt >= REJECT_CYC - 1'b1) begin
                    next_state = `RDT_ST_RELOAD;
                end
            end
            default: begin
                next_state = `RDT_ST_RUN;
            end
        endcase
    end

    // filter counters and reset side effects
    always @(posedge core_clk) begin
        if (rst) begin
            // power-on counts as long settled, device is ready
            state <= `RDT_ST_RUN;
            filtCnt <= {`RDT_FILT_W{1'b0}};
            waitCnt <= SLEEPOUT_W;
            sleepAtReset <= 1'b0;
            displayBlank <= 1'b0;
            settingsReload <= 1'b0;
            settingsDefault <= 1'b0;
            commandReady <= 1'b1;
            sleepExitAllowed <= 1'b1;
        end else begin
            state <= next_state;
            settingsReload <= 1'b0;
            settingsDefault <= 1'b0;
            // stretch counter restarts on every state change
            if (next_state != state) begin
                filtCnt <= {`RDT_FILT_W{1'b0}};
            end else if (filtCnt != FULL_CYC) begin
                filtCnt <= filtCnt + 1'b1;
            end
            if (state == `RDT_ST_LOWCNT && next_state == `RDT_ST_HELD) begin
                // reset has started: blank and fall back to defaults
                sleepAtReset <= sleepOut;
                displayBlank <= 1'b1;
                settingsDefault <= 1'b1;
                commandReady <= 1'b0;
                sleepExitAllowed <= 1'b0;
            end
            if (inReset) begin
                // release time counts from the accepted rising edge
                waitCnt <= {`RDT_WAIT_W{1'b0}};
            end else if (waitCnt < SLEEPOUT_W) begin
                waitCnt <= waitCnt + 1'b1;
            end
            if (state == `RDT_ST_HIGHCNT && next_state == `RDT_ST_RELOAD) begin
                settingsReload <= 1'b1;
            end
            if (state == `RDT_ST_RELOAD || state == `RDT_ST_RUN) begin
                // reload length depends on the sleep mode at reset time
                if (waitCnt >= (sleepAtReset ? SLEEPOUT_W : SLEEPIN_W)) begin
                    displayBlank <= 1'b0;
                    commandReady <= 1'b1;
                end
                if (waitCnt >= EXIT_W) begin
                    sleepExitAllowed <= 1'b1;
                end
            end
        end
    end

    // pixel capture: one pixel per pixel clock while enable is high
    reg [`RDT_COL_W-1:0] colCnt; // pixels taken in current line
    reg hsyncPrev; // line sync level at last pixel edge
    reg vsyncPrev;
    reg newFrame; // next pixel opens a frame
    reg newLine; // next pixel opens a line
    reg pushValid;
    reg [`RDT_WORD_W-1:0] pushWord;
    wire pushReady;
    wire lineStart = pclkEdge & hsyncPrev & ~hsyncOld;
    wire frameStart = pclkEdge & vsyncPrev & ~vsyncOld;

    // line bookkeeping and fifo feed
    always @(posedge core_clk) begin
        if (rst) begin
            colCnt <= {`RDT_COL_W{1'b0}};
            hsyncPrev <= 1'b1;
            vsyncPrev <= 1'b1;
            newFrame <= 1'b0;
            newLine <= 1'b0;
            pushValid <= 1'b0;
            pushWord <= {`RDT_WORD_W{1'b0}};
            lineLengthError <= 1'b0;
            pixelOverrun <= 1'b0;
        end else begin
            pushValid <= 1'b0;
            if (pclkEdge) begin
                hsyncPrev <= hsyncOld;
                vsyncPrev <= vsyncOld;
            end
            if (frameStart) begin
                newFrame <= 1'b1;
                lineLengthError <= 1'b0;
            end
            if (lineStart) begin
                // a line with pixels must hold exactly the active count
                if (colCnt != {`RDT_COL_W{1'b0}} && colCnt != `RDT_H_ACTIVE) begin
                    lineLengthError <= 1'b1;
                end
                colCnt <= {`RDT_COL_W{1'b0}};
                newLine <= 1'b1;
            end else if (pclkEdge & deOld & ~displayBlank) begin
                // only enable-marked pixels count, blanking drops them
                colCnt <= colCnt + 1'b1;
                newFrame <= 1'b0;
                newLine <= 1'b0;
                pushValid <= 1'b1;
                pushWord <= {newFrame, newLine, pixOld};
                // pixel source cannot stall, so a full buffer loses the word
                if (~pushReady) begin
                    pixelOverrun <= 1'b1;
                end
            end
        end
    end

    // small buffer between capture and consumer
    rdt_fifo #(
        .WIDTH(`RDT_WORD_W),
        .DEPTH(`RDT_FIFO_DEPTH),
        .AW(`RDT_FIFO_AW)
    ) u_fifo (
        .core_clk(core_clk),
        .rst(rst),
        .inValid(pushValid),
        .inReady(pushReady),
        .inData(pushWord),
        .outValid(pixValid),
        .outReady(pixReady),
        .outData(pixWord)
    );
endmodule

/* test/rdt_receiver_assertions.sv */
// checker for the receiver reset filter and reload waits
// assumes binding to rdt_receiver with the same shortened waits
`timescale 1ns/1ps
module rdt_receiver_assertions #(
    parameter RELOAD_SLEEPIN_CYC = 50,
    parameter RELOAD_SLEEPOUT_CYC = 200,
    parameter SLEEP_EXIT_CYC = 200
) (
    input wire core_clk,
    input wire rst,
    input wire hw_reset_n,
    input wire sleepOut,
    input wire displayBlank,
    input wire settingsReload,
    input wire settingsDefault,
    input wire commandReady,
    input wire sleepExitAllowed
);
    reg [8:0] lowRun; // raw pin low run, saturating
    reg [8:0] highRun; // raw pin high run, saturating
    reg [15:0] sinceRel; // cycles since accepted release
    // run lengths on the raw pin; sync delay is covered by slack
    always @(posedge core_clk) begin
        if (rst) begin
            lowRun <= 9'h000;
            highRun <= 9'h000;
        end else begin
            lowRun <= hw_reset_n ? 9'h000 : lowRun + {8'h00, ~&lowRun};
            highRun <= !hw_reset_n ? 9'h000 : highRun + {8'h00, ~&highRun};
        end
        sinceRel <= (rst || settingsReload) ? 16'h0000 : sinceRel + {15'h0000, ~&sinceRel};
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    a_short_reject: assert property (settingsDefault |-> lowRun >= 9'h0c7)
        else $error("reset taken on a short low");
    a_long_reset: assert property (lowRun == 9'h0d2 |-> displayBlank)
        else $error("long low did not reset");
    a_glitch_release: assert property (settingsReload |-> highRun >= 9'h0c7)
        else $error("release taken on a short high");
    a_entry_outputs: assert property (settingsDefault |-> displayBlank && !commandReady)
        else $error("reset entry outputs wrong");
    a_blank_rise: assert property ($rose(displayBlank) |-> settingsDefault)
        else $error("blank without defaults");
    a_blank_ready: assert property (displayBlank != commandReady)
        else $error("blank and ready disagree");
    a_reload_wait: assert property ($rose(commandReady) |->
        sinceRel + 5 >= (sleepOut ? RELOAD_SLEEPOUT_CYC : RELOAD_SLEEPIN_CYC) &&
        sinceRel <= (sleepOut ? RELOAD_SLEEPOUT_CYC : RELOAD_SLEEPIN_CYC) + 3)
        else $error("reload wait length wrong");
    a_exit_wait: assert property ($rose(sleepExitAllowed) |->
        sinceRel + 5 >= SLEEP_EXIT_CYC && sinceRel <= SLEEP_EXIT_CYC + 3)
        else $error("sleep exit wait wrong");
endmodule
bind rdt_receiver rdt_receiver_assertions #(.RELOAD_SLEEPIN_CYC(RELOAD_SLEEPIN_CYC),
    .RELOAD_SLEEPOUT_CYC(RELOAD_SLEEPOUT_CYC), .SLEEP_EXIT_CYC(SLEEP_EXIT_CYC)) u_chk (
    .core_clk(core_clk), .rst(rst), .hw_reset_n(hw_reset_n), .sleepOut(sleepOut),
    .displayBlank(displayBlank), .settingsReload(settingsReload),
    .settingsDefault(settingsDefault), .commandReady(commandReady),
    .sleepExitAllowed(sleepExitAllowed));

/* test/rdt_host_model.sv */
// host model: rgb line and frame timing plus the reset pin
// assumes nothing of core_clk; the link clock stops between frames
`timescale 1ns/1ps
module rdt_host_model #(
    parameter HS = 3, // widths and porches adjustable
    parameter HB = 3,
    parameter HA = 320,
    parameter HF = 3,
    parameter VS = 2,
    parameter VB = 2,
    parameter VF = 2
) (
    output reg pixel_clock,
    output reg hsync_n,
    output reg vsync_n,
    output reg dataEnable,
    output reg [17:0] pixel_data_bus,
    output reg hw_reset_n
);
    integer seed = 81; // fixed seed for pixel data
    integer rnd;
    integer hCut = 0; // active pixels dropped from each line, for error tests
    initial begin
        {pixel_clock, dataEnable, pixel_data_bus} = 20'h0_0000;
        {hsync_n, vsync_n, hw_reset_n} = 3'h7;
    end
    // one 200 ns link clock; pins change at the low edge
    // rate slowed so the sampling core sees every phase
    // calls start on a core edge, so non-blocking updates avoid sampling races
    task automatic pclk(input h, input v, input de);
        begin
            hsync_n <= h;
            vsync_n <= v;
            dataEnable <= de;
            rnd = $random(seed);
            pixel_data_bus <= rnd[17:0]; // idle bus keeps moving
            #100 pixel_clock <= 1'b1;
            #100 pixel_clock <= 1'b0;
        end
    endtask
    // sync, back porch, active pixels, front porch
    task automatic line(input v, input act);
        integer i;
        begin
            for (i = 0; i < HS + HB + HA + HF; i = i + 1) begin
                pclk(i >= HS, v,
                    act && i >= HS + HB && i < HS + HB + HA - hCut);
            end
        end
    endtask
    // active line count cut short to keep runs brief
    // frame rate not held, a limitation of the short frames
    task automatic frame(input integer nAct);
        integer j;
        begin
            for (j = 0; j < VS + VB + nAct + VF; j = j + 1) begin
                line(j >= VS, j >= VS + VB && j < VS + VB + nAct);
            end
        end
    endtask
    // low pulse, optionally split by a high glitch
    task automatic resetPulse(input integer lowNs, input integer glitchNs);
        begin
            hw_reset_n <= 1'b0;
            #(lowNs);
            if (glitchNs > 0) begin
                hw_reset_n <= 1'b1;
                #(glitchNs) hw_reset_n <= 1'b0;
                #(lowNs);
            end
            hw_reset_n <= 1'b1;
        end
    endtask
endmodule

/* test/rdt_receiver_tb_top.sv */
// bench for the rgb receiver: host model, scoreboard, reset scenarios
// assumes the shortened waits below; link clock made by the host model
`timescale 1ns/1ps
module rdt_receiver_tb_top;
    localparam integer P_IN = 50; // reload wait from sleep-in
    localparam integer P_OUT = 200; // reload wait from sleep-out
    localparam integer P_EXIT = 200; // sleep exit wait
    reg core_clk = 1'b0;
    reg rst = 1'b1;
    reg sleepOut = 1'b0;
    reg pixReady = 1'b0;
    wire pixel_clock, hsync_n, vsync_n, dataEnable, hw_reset_n, pixValid;
    wire displayBlank, settingsReload, settingsDefault, commandReady;
    wire sleepExitAllowed, lineLengthError, pixelOverrun;
    wire [17:0] pixel_data_bus;
    wire [19:0] pixWord;
    integer nMismatch = 0;
    integer checkCount = 0;
    integer seed = 81; // fixed seed for consumer stalls
    integer rnd, nDef = 0, nRel = 0, relCnt = 0, readyAt = 0, exitAt = 0, drained = 0;
    reg modelOn = 1'b0; // scoreboard live
    reg drain = 1'b0; // consumer never stalls
    reg newFrame = 1'b0;
    reg newLine = 1'b0;
    reg sawBlank = 1'b0;
    reg [19:0] expQ[$]; // expected fifo words
    initial forever #12.5 core_clk = ~core_clk;
    rdt_host_model u_host (.pixel_clock(pixel_clock), .hsync_n(hsync_n), .vsync_n(vsync_n),
        .dataEnable(dataEnable), .pixel_data_bus(pixel_data_bus), .hw_reset_n(hw_reset_n));
    rdt_receiver #(.RELOAD_SLEEPIN_CYC(P_IN), .RELOAD_SLEEPOUT_CYC(P_OUT),
        .SLEEP_EXIT_CYC(P_EXIT)) u_dut (.core_clk(core_clk), .rst(rst),
        .pixel_clock(pixel_clock), .hsync_n(hsync_n), .vsync_n(vsync_n),
        .dataEnable(dataEnable), .pixel_data_bus(pixel_data_bus), .hw_reset_n(hw_reset_n),
        .sleepOut(sleepOut), .pixValid(pixValid), .pixReady(pixReady), .pixWord(pixWord),
        .displayBlank(displayBlank), .settingsReload(settingsReload),
        .settingsDefault(settingsDefault), .commandReady(commandReady),
        .sleepExitAllowed(sleepExitAllowed), .lineLengthError(lineLengthError),
        .pixelOverrun(pixelOverrun));
    task closeOut;
        begin
            $display("mismatches %0d, checks %0d", nMismatch, checkCount);
            if (nMismatch == 0 && checkCount > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    task check(input logic [31:0] seen, input logic [31:0] want);
        begin
            checkCount = checkCount + 1;
            if (seen !== want) begin
                nMismatch = nMismatch + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    // bounded wait for ready (0) or sleep exit (1)
    task waitFor(input integer sel);
        integer k;
        begin
            for (k = 0; k < 3000 && (sel ? sleepExitAllowed : commandReady) !== 1'b1; k = k + 1)
                @(posedge core_clk);
            if ((sel ? sleepExitAllowed : commandReady) !== 1'b1) begin
                nMismatch = nMismatch + 1;
                closeOut;
            end
        end
    endtask
    // bench model: flags from sync pins, one word per enabled pixel
    always @(posedge pixel_clock) begin
        if (!vsync_n) newFrame = 1'b1;
        if (!hsync_n) newLine = 1'b1;
        if (dataEnable) begin
            if (modelOn) expQ.push_back({newFrame, newLine, pixel_data_bus});
            newFrame = 1'b0;
            newLine = 1'b0;
        end
    end
    // consumer with random stalls, pulse counters, wait timers
    always @(posedge core_clk) begin
        rnd = $random(seed);
        pixReady <= drain || (modelOn && rnd[0]);
        relCnt = (settingsReload === 1'b1) ? 0 : relCnt + 1;
        if (settingsDefault === 1'b1) nDef = nDef + 1;
        if (settingsReload === 1'b1) nRel = nRel + 1;
        if (displayBlank === 1'b1) sawBlank = 1'b1;
        if (commandReady !== 1'b1) readyAt = relCnt;
        if (sleepExitAllowed !== 1'b1) exitAt = relCnt;
        if (pixValid === 1'b1 && pixReady === 1'b1) begin
            drained = drained + 1;
            if (modelOn && expQ.size() > 0) check(pixWord, expQ.pop_front());
            else if (modelOn) check(1, 0);
        end
    end
    // watchdog: a hang ends the run as a failure
    initial begin
        #2400000;
        nMismatch = nMismatch + 1;
        closeOut;
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        modelOn = 1'b1;
        u_host.frame(3);
        repeat (40) @(posedge core_clk);
        check(expQ.size(), 0);
        check({lineLengthError, pixelOverrun}, 0);
        modelOn = 1'b0;
        u_host.resetPulse(3750, 0);
        repeat (20) @(posedge core_clk);
        check(nDef, 0);
        check(sawBlank, 0);
        u_host.resetPulse(7500, 2500);
        waitFor(0);
        check(nDef, 1);
        check(nRel, 1);
        check(sawBlank, 1);
        check(readyAt + 5 >= P_IN && readyAt <= P_IN + 3, 1);
        waitFor(1);
        check(exitAt + 5 >= P_EXIT && exitAt <= P_EXIT + 3, 1);
        sleepOut <= 1'b1;
        u_host.resetPulse(10000, 0);
        waitFor(0);
        check(nDef, 2);
        check(readyAt + 5 >= P_OUT && readyAt <= P_OUT + 3, 1);
        drained = 0;
        u_host.hCut = 10; // short lines must raise the length flag
        u_host.frame(1);
        check(pixelOverrun, 1);
        check(lineLengthError, 1);
        @(posedge core_clk);
        drain <= 1'b1;
        repeat (12) @(posedge core_clk);
        check(drained, 4);
        check(pixValid, 0);
        closeOut;
    end
endmodule
